// ===== lpe_host.sv
// host model speaking the serial control port
`timescale 1ns/1ps
`default_nettype none
module lpe_host (
    input wire logic clk,
    output var lpe_pkg::lpe_cpu_pins_s pins,
    input wire logic sdo,
    output var logic rd_valid,
    output var logic [7:0] rd_data
);
    import lpe_pkg::*;
    // port idle: deselected, clock parked high
    initial begin
        pins = '{cs_n: 1'b1, sclk: 1'b1, sdi: 1'b0};
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end
    // hp is the sclk half period; sdo is sampled late in the low phase to clear the synchroniser
    task automatic xfer(input logic rw, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input int hp);
        logic [15:0] f;
        logic [7:0] r;
        f = {d, 1'b0, a, rw};
        r = 8'h00;
        @(posedge clk);
        pins.cs_n <= 1'b0;
        repeat (hp) @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            pins.sclk <= 1'b0;
            pins.sdi <= f[i];
            repeat (hp) @(posedge clk);
            if (i > 7) r[i-8] = sdo;
            pins.sclk <= 1'b1;
            repeat (hp) @(posedge clk);
        end
        pins.cs_n <= 1'b1;
        pins.sdi <= ~pins.sdi; // leave no stale data bit behind
        rd_data <= r;
        rd_valid <= rw;
        @(posedge clk);
        rd_valid <= 1'b0;
        repeat (hp) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== lpe_line_path_enable_regs.sv
// global path enable and channel interrupt gate registers behind the serial port
`timescale 1ns/1ps
`default_nettype none
module lpe_line_path_enable_regs (
    input wire logic clk,
    input wire logic rst,
    input wire lpe_pkg::lpe_cpu_pins_s cpu_pins,
    output var logic sdo,
    output var logic sdo_oe_n,
    input wire logic [lpe_pkg::CHANNELS-1:0] transmit_driver_on,
    input wire logic [lpe_pkg::CHANNELS-1:0] tx_pos_data,
    input wire logic [lpe_pkg::CHANNELS-1:0] tx_neg_data,
    output var logic [lpe_pkg::CHANNELS-1:0] tx_line_positive,
    output var logic [lpe_pkg::CHANNELS-1:0] tx_line_negative,
    output var logic [lpe_pkg::CHANNELS-1:0] tx_line_oe_n,
    output var logic [lpe_pkg::CHANNELS-1:0] receive_section_on,
    input wire logic [lpe_pkg::CHANNELS-1:0] chan_int_src,
    output var logic [lpe_pkg::CHANNELS-1:0] chan_int_out,
    output var logic int_n
);
    import lpe_pkg::*;

    localparam int PIN_W = $bits(lpe_cpu_pins_s) + CHANNELS;
    localparam logic [PIN_W-1:0] PIN_RESET = {3'b110, {CHANNELS{1'b0}}};

    // read mux, shared by the frame engine at the dummy bit
    function automatic logic [DATA_W-1:0] read_value(input logic [ADDR_W-1:0] a,
                                                     input logic [DATA_W-1:0] path,
                                                     input logic [DATA_W-1:0] gate);
        logic [DATA_W-1:0] v;
        v = READ_ZERO;
        if (a == ADDR_PATH_ENABLE) begin
            v = path;
        end else if (a == ADDR_INT_GATE) begin
            v = gate;
        end
        return v;
    endfunction

    lpe_cpu_pins_s pins_f;
    logic [CHANNELS-1:0] txen_f;
    logic [PIN_W-1:0] pins_sync;

    // chip select idles high; sclk idles high so no false edge at reset
    lpe_sync #(
        .WIDTH(PIN_W),
        .RESET_VALUE(PIN_RESET)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .async_in({cpu_pins, transmit_driver_on}),
        .sync_out(pins_sync)
    );

    assign pins_f = pins_sync[PIN_W-1:CHANNELS];
    assign txen_f = pins_sync[CHANNELS-1:0];

    // serial frame engine
    lpe_state_e state;
    lpe_state_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic rw;
    logic next_rw;
    logic [DATA_W-1:0] shift;
    logic [DATA_W-1:0] next_shift;
    logic sclk_q;
    logic next_sdo;
    logic next_sdo_oe_n;
    logic wr_stb;
    logic [DATA_W-1:0] wr_data;
    logic sclk_rise;
    logic sclk_fall;

    logic [DATA_W-1:0] path_enable;
    logic [DATA_W-1:0] int_gate;

    assign sclk_rise = pins_f.sclk & ~sclk_q;
    assign sclk_fall = ~pins_f.sclk & sclk_q;

    // frame: read flag, six address bits lsb first, dummy, eight data bits lsb first
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_addr = addr;
        next_rw = rw;
        next_shift = shift;
        next_sdo = sdo;
        next_sdo_oe_n = 1'b1;
        wr_stb = 1'b0;
        wr_data = {pins_f.sdi, shift[DATA_W-1:1]};
        unique case (state)
            ST_IDLE: begin
                if (!pins_f.cs_n) begin
                    next_state = ST_HEAD;
                    next_cnt = BIT_RW;
                end
            end
            ST_HEAD: begin
                if (sclk_rise) begin
                    if (cnt == BIT_RW) begin
                        next_rw = pins_f.sdi;
                    end else if (cnt < BIT_DUMMY) begin
                        next_addr = {pins_f.sdi, addr[ADDR_W-1:1]};
                    end else begin
                        // read data captured here so it is stable for the whole byte
                        next_state = ST_DATA;
                        next_shift = read_value(addr, path_enable, int_gate);
                    end
                    next_cnt = cnt + CNT_ONE;
                end
            end
            ST_DATA: begin
                next_sdo_oe_n = ~rw;
                if (rw && sclk_fall && cnt != BIT_DONE) begin
                    next_sdo = shift[0];
                    next_shift = {1'b0, shift[DATA_W-1:1]};
                end
                if (sclk_rise && cnt != BIT_DONE) begin
                    if (!rw) begin
                        next_shift = wr_data;
                        wr_stb = (cnt == BIT_LAST);
                    end
                    next_cnt = cnt + CNT_ONE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // raising chip select aborts any frame; a short write never commits
        if (pins_f.cs_n) begin
            next_state = ST_IDLE;
            next_sdo_oe_n = 1'b1;
            wr_stb = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            cnt <= BIT_RW;
            addr <= '0;
            rw <= 1'b0;
            shift <= '0;
            sclk_q <= 1'b1;
            sdo <= 1'b0;
            sdo_oe_n <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            addr <= next_addr;
            rw <= next_rw;
            shift <= next_shift;
            sclk_q <= pins_f.sclk;
            sdo <= next_sdo;
            sdo_oe_n <= next_sdo_oe_n;
        end
    end

    // register bank
    logic [DATA_W-1:0] next_path_enable;
    logic [DATA_W-1:0] next_int_gate;

    // reserved bits are masked so they always read zero
    always_comb begin
        next_path_enable = path_enable;
        next_int_gate = int_gate;
        if (wr_stb && addr == ADDR_PATH_ENABLE) begin
            next_path_enable = wr_data & PATH_ENABLE_MASK;
        end
        if (wr_stb && addr == ADDR_INT_GATE) begin
            next_int_gate = wr_data & INT_GATE_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            path_enable <= PATH_ENABLE_RESET;
            int_gate <= INT_GATE_RESET;
        end else begin
            path_enable <= next_path_enable;
            int_gate <= next_int_gate;
        end
    end

    // channel outputs
    logic [CHANNELS-1:0] next_rx_on;
    logic [CHANNELS-1:0] drive_en;
    logic [CHANNELS-1:0] next_tx_pos;
    logic [CHANNELS-1:0] next_tx_neg;
    logic [CHANNELS-1:0] next_tx_oe_n;
    logic [CHANNELS-1:0] next_chan_int;

    // driver needs both the software bit and the pin; an idle driver also holds zero data
    always_comb begin
        next_rx_on = path_enable[RX_ON_LSB +: CHANNELS];
        drive_en = path_enable[TX_ON_LSB +: CHANNELS] & txen_f;
        next_tx_oe_n = ~drive_en;
        next_tx_pos = tx_pos_data & drive_en;
        next_tx_neg = tx_neg_data & drive_en;
        next_chan_int = chan_int_src & int_gate[CHANNELS-1:0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            receive_section_on <= '0;
            tx_line_oe_n <= '1;
            tx_line_positive <= '0;
            tx_line_negative <= '0;
            chan_int_out <= '0;
            int_n <= 1'b1;
        end else begin
            receive_section_on <= next_rx_on;
            tx_line_oe_n <= next_tx_oe_n;
            tx_line_positive <= next_tx_pos;
            tx_line_negative <= next_tx_neg;
            chan_int_out <= next_chan_int;
            int_n <= ~|next_chan_int;
        end
    end
endmodule
`default_nettype wire

// ===== lpe_line_path_enable_regs_tb.sv
// self-checking bench for the line path enable register bank
`timescale 1ns/1ps
`default_nettype none
module lpe_line_path_enable_regs_tb;
    import lpe_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] drv_on = 3'h0, pos_d = 3'h0, neg_d = 3'h0, src = 3'h0;
    lpe_cpu_pins_s pins;
    logic sdo, sdo_oe_n, int_n, rd_valid;
    logic [2:0] tx_p, tx_n, oe_n, rx_on, int_out;
    logic [7:0] rd_data;
    logic [7:0] exp_q[$];
    int n_errors = 0, samples_checked = 0, cyc = 0, hp = 6;
    lpe_line_path_enable_regs DUT (.clk(clk), .rst(rst), .cpu_pins(pins), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .transmit_driver_on(drv_on), .tx_pos_data(pos_d), .tx_neg_data(neg_d), .tx_line_positive(tx_p),
        .tx_line_negative(tx_n), .tx_line_oe_n(oe_n), .receive_section_on(rx_on), .chan_int_src(src),
        .chan_int_out(int_out), .int_n(int_n));
    lpe_host h (.clk(clk), .pins(pins), .sdo(sdo), .rd_valid(rd_valid), .rd_data(rd_data));
    always #2 clk = ~clk;
    // line data and interrupt sources churn every cycle
    always @(posedge clk) begin
        pos_d <= 3'($urandom);
        neg_d <= 3'($urandom);
        src <= 3'($urandom);
    end
    // read results are matched against the oldest noted value
    always @(posedge clk) begin
        if (rd_valid === 1'b1) chk("read_data", exp_q.pop_front(), rd_data);
    end
    // hang guard, far above the roughly 20000 cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        h.xfer(1'b1, a, 8'h00, hp);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        chk("rx_on_rst", 8'(rx_on), 8'h00);
        chk("oe_n_rst", 8'(oe_n), 8'h07);
        chk("int_rst", 8'({int_out, int_n}), 8'h01);
        rd(ADDR_PATH_ENABLE, PATH_ENABLE_RESET);
        rd(ADDR_INT_GATE, INT_GATE_RESET);
    endtask
    initial begin
        logic [7:0] d, g;
        logic [2:0] s;
        void'($urandom(32'he003bc58));
        do_reset();
        for (int k = 0; k < 12; k++) begin
            @(posedge clk);
            hp = ($urandom % 2 == 0) ? 6 : 10;
            d = 8'($urandom);
            g = 8'($urandom);
            drv_on <= 3'($urandom);
            h.xfer(1'b0, ADDR_PATH_ENABLE, d, hp);
            h.xfer(1'b0, ADDR_INT_GATE, g, hp);
            h.xfer(1'b0, 6'h21, 8'hFF, hp);
            repeat (12) @(posedge clk);
            chk("rx_on", 8'(rx_on), 8'(d[6:4]));
            chk("oe_n", 8'(oe_n), {5'h00, ~(d[2:0] & drv_on)});
            // src seen at this edge is what the design registers at this same edge
            s = src;
            #1;
            chk("int_out", 8'({int_out, int_n}), 8'({s & g[2:0], ~|(s & g[2:0])}));
            rd(ADDR_PATH_ENABLE, d & PATH_ENABLE_MASK);
            rd(ADDR_INT_GATE, g & INT_GATE_MASK);
            rd(6'h21, READ_ZERO);
        end
        do_reset();
        repeat (4) @(posedge clk);
        chk("pending_reads", 8'(exp_q.size()), 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire

// ===== lpe_pkg.sv
// constants, types and register layout of the line path enable register bank
package lpe_pkg;

    localparam int CHANNELS = 3;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int SYNC_STAGES = 3;
    localparam int CNT_W = 5;

    // register offsets on the serial port
    localparam logic [ADDR_W-1:0] ADDR_PATH_ENABLE = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_INT_GATE = 6'h20;

    // field positions inside the path enable register
    localparam int RX_ON_LSB = 4;
    localparam int TX_ON_LSB = 0;

    // writable bits and reset values
    localparam logic [DATA_W-1:0] PATH_ENABLE_MASK = 8'h77;
    localparam logic [DATA_W-1:0] INT_GATE_MASK = 8'h07;
    localparam logic [DATA_W-1:0] PATH_ENABLE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] INT_GATE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    // serial frame layout, counted in sclk rising edges
    localparam logic [CNT_W-1:0] BIT_RW = 5'h00;
    localparam logic [CNT_W-1:0] BIT_DUMMY = 5'h07;
    localparam logic [CNT_W-1:0] BIT_LAST = 5'h0F;
    localparam logic [CNT_W-1:0] BIT_DONE = 5'h10;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

    // frame engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HEAD = 3'b010,
        ST_DATA = 3'b100
    } lpe_state_e;

    // serial port input pins, carried together
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } lpe_cpu_pins_s;

endpackage

// ===== lpe_regs_monitor.sv
// assertion checker for the line path enable register bank
`timescale 1ns/1ps
`default_nettype none
module lpe_regs_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire lpe_pkg::lpe_cpu_pins_s cpu_pins,
    input wire logic sdo_oe_n,
    input wire logic [lpe_pkg::CHANNELS-1:0] transmit_driver_on,
    input wire logic [lpe_pkg::CHANNELS-1:0] tx_pos_data,
    input wire logic [lpe_pkg::CHANNELS-1:0] tx_neg_data,
    input wire logic [lpe_pkg::CHANNELS-1:0] tx_line_positive,
    input wire logic [lpe_pkg::CHANNELS-1:0] tx_line_negative,
    input wire logic [lpe_pkg::CHANNELS-1:0] tx_line_oe_n,
    input wire logic [lpe_pkg::CHANNELS-1:0] receive_section_on,
    input wire logic [lpe_pkg::CHANNELS-1:0] chan_int_src,
    input wire logic [lpe_pkg::CHANNELS-1:0] chan_int_out,
    input wire logic int_n
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // an enabled driver must pass its data, a disabled one must stay quiet
    a_pos_data_gated: assert property (tx_line_positive == ($past(tx_pos_data) & ~tx_line_oe_n))
        else $error("positive line pulse does not follow data and enable");
    a_neg_data_gated: assert property (tx_line_negative == ($past(tx_neg_data) & ~tx_line_oe_n))
        else $error("negative line pulse does not follow data and enable");
    a_tristate_quiet: assert property (((tx_line_positive | tx_line_negative) & tx_line_oe_n) == 3'h0)
        else $error("pulse on a tri-stated line pair");
    a_pin_low_off: assert property ((transmit_driver_on == 3'h0) [*8] |-> tx_line_oe_n == 3'h7)
        else $error("driver on while enable pins low");
    a_int_gate_src: assert property ((chan_int_out & ~$past(chan_int_src)) == 3'h0)
        else $error("channel interrupt without source");
    a_int_n_any: assert property (int_n == !(|chan_int_out))
        else $error("combined interrupt disagrees with channels");
    a_reset_clears: assert property ($fell(rst) |-> tx_line_oe_n == 3'h7 && receive_section_on == 3'h0 && chan_int_out == 3'h0)
        else $error("outputs not cleared by reset");
    a_idle_rx_hold: assert property (cpu_pins.cs_n [*8] |=> $stable(receive_section_on))
        else $error("receive enable moved with port idle");
    // port deselected for eight cycles must no longer drive its data pin
    a_idle_sdo_off: assert property (cpu_pins.cs_n [*8] |-> sdo_oe_n)
        else $error("serial output driven while deselected");
endmodule
bind lpe_line_path_enable_regs lpe_regs_monitor u_mon (.clk(clk), .rst(rst), .cpu_pins(cpu_pins), .sdo_oe_n(sdo_oe_n),
    .transmit_driver_on(transmit_driver_on), .tx_pos_data(tx_pos_data), .tx_neg_data(tx_neg_data),
    .tx_line_positive(tx_line_positive), .tx_line_negative(tx_line_negative), .tx_line_oe_n(tx_line_oe_n),
    .receive_section_on(receive_section_on), .chan_int_src(chan_int_src), .chan_int_out(chan_int_out),
    .int_n(int_n));
`default_nettype wire

// ===== lpe_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module lpe_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output var logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_sync_out;

    // a bit moves only once stages two and three agree; stage one feeds stage two alone
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_sync_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            sync_out <= next_sync_out;
        end
    end
endmodule
`default_nettype wire
